// ==== core/ee_pkg.sv ====
// Shared constants, states and carriers for the two-wire memory target.
// Assumes a single 25 MHz system clock that oversamples the bus pins.
package ee_pkg;

   // System clock rate.
   localparam int unsigned EE_CLK_MHZ = 25;

   // Array organisation: 512 pages of 128 bytes, 16-bit word address.
   localparam int unsigned EE_ADDR_BITS = 16;
   localparam int unsigned EE_PAGE_BYTES = 128;
   localparam int unsigned EE_PAGE_BITS = 7;
   localparam int unsigned EE_PAGE_COUNT = 512;

   // Bus word framing.
   localparam logic [3:0] EE_BITS_PER_WORD = 4'h8;

   // Fixed upper five bits of the device address word.
   localparam logic [4:0] EE_DEV_CODE = 5'h14;

   // Address counter value after reset.
   localparam logic [15:0] EE_ADDR_RESET = 16'h0000;

   // Self-timed write duration in microseconds, per supply grade.
   localparam int unsigned EE_WRITE_TIME_US = 10000;
   localparam int unsigned EE_WRITE_TIME_LV_US = 20000;

   // Longest times scale exactly to whole clock cycles.
   localparam int unsigned EE_WRITE_CYCLES = EE_WRITE_TIME_US * EE_CLK_MHZ;
   localparam int unsigned EE_WRITE_CYCLES_LV = EE_WRITE_TIME_LV_US * EE_CLK_MHZ;

   // Protocol states.
   typedef enum logic [3:0] {
      EE_ST_IDLE  = 4'h0,
      EE_ST_DEV   = 4'h1,
      EE_ST_AHI   = 4'h2,
      EE_ST_ALO   = 4'h3,
      EE_ST_WDAT  = 4'h4,
      EE_ST_ACK   = 4'h5,
      EE_ST_RD    = 4'h6,
      EE_ST_RACK  = 4'h7,
      EE_ST_RLOAD = 4'h8
   } ee_state_t;

   // Pin levels that cross into the clock domain together.
   typedef struct packed {
      logic scl;
      logic sda;
      logic strap_hi;
      logic strap_lo;
      logic wp;
   } ee_pins_t;

   // One byte bound for the page buffer.
   typedef struct packed {
      logic [6:0] idx;
      logic [7:0] data;
   } ee_load_t;

endpackage

// ==== core/ee_sync.sv ====
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes each bit is a slow level; no bit relation across the group is kept.
`timescale 1ns/100ps
module ee_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset.
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Levels.
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta;

   // Resetting high matches the idle level of both bus wires, so no edge shows while the
   // stages fill; a protect input briefly reads as set, which is the safe side.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta <= '1;
         q_o  <= '1;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end

endmodule

// ==== core/ee_mem.sv ====
// Storage array with a one-page write buffer and a slow commit walk.
// Assumes loads and commits never overlap; the caller holds off loads while busy.
`timescale 1ns/100ps
module ee_mem
   import ee_pkg::*;
#(
   parameter int unsigned PAGE_BYTES = EE_PAGE_BYTES,
   parameter int unsigned PAGES      = EE_PAGE_COUNT
) (
   // Clock and reset.
   input  wire logic                            clk_i,
   input  wire logic                            rst_n_i,
   // Page buffer fill.
   input  wire logic                            load_en_i,
   input  wire ee_load_t                        load_i,
   input  wire logic                            discard_i,
   // Commit into the array.
   input  wire logic                            commit_i,
   input  wire logic [$clog2(PAGES)-1:0]        page_i,
   // Read port.
   input  wire logic [EE_ADDR_BITS-1:0]         raddr_i,
   output logic      [7:0]                      rdata_o
);

   localparam int unsigned IW = $clog2(PAGE_BYTES);

   logic [7:0]              array [PAGES*PAGE_BYTES];
   logic [7:0]              page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0]   valid;
   logic                    walking;
   logic [IW-1:0]           walk_idx;
   logic [$clog2(PAGES)-1:0] walk_page;

   // Only bytes that were really sent are written, so a partial page leaves the rest intact.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         valid <= '0;
      end else if (discard_i || (walking && walk_idx == IW'(PAGE_BYTES - 1))) begin
         valid <= '0;
      end else if (load_en_i) begin
         valid[load_i.idx[IW-1:0]] <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (load_en_i) begin
         page_buf[load_i.idx[IW-1:0]] <= load_i.data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         walking   <= 1'b0;
         walk_idx  <= '0;
         walk_page <= '0;
      end else if (commit_i) begin
         walking   <= 1'b1;
         walk_idx  <= '0;
         walk_page <= page_i;
      end else if (walking) begin
         walk_idx <= walk_idx + 1'b1;
         if (walk_idx == IW'(PAGE_BYTES - 1)) begin
            walking <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (walking && valid[walk_idx]) begin
         array[{walk_page, walk_idx}] <= page_buf[walk_idx];
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= array[raddr_i];
   end

endmodule

// ==== core/ee_target.sv ====
// Two-wire serial memory target: bus protocol, address counter and write timing.
// Assumes the bus host and pull-up sit outside; every pin is oversampled by clk_i.
`timescale 1ns/100ps
module ee_target
   import ee_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = EE_WRITE_CYCLES
) (
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Two-wire bus.
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_o,
   // Straps and protection.
   input  wire logic device_select_strap_hi_i,
   input  wire logic device_select_strap_lo_i,
   input  wire logic write_protect_i,
   // Status.
   output logic      standby_o,
   output logic      write_busy_o
);

   localparam int unsigned CW = $clog2(WRITE_CYCLES + 1);

   ee_pins_t          pins_raw;
   ee_pins_t          pins;
   logic              scl_d;
   logic              sda_d;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_det;
   logic              stop_det;

   ee_state_t         state;
   ee_state_t         after;
   ee_state_t         next_after;
   logic [3:0]        bitcnt;
   logic [7:0]        sr;
   logic [7:0]        out_sr;
   logic              drive_low;

   logic [15:0]       addr_cnt;
   logic [7:0]        rdata;
   logic              rx_state;
   logic              byte_end;
   logic              dev_match;
   logic              ld_hi;
   logic              ld_lo;
   logic              ld_data;
   logic              rd_load;

   logic              page_dirty;
   logic              busy;
   logic [CW-1:0]     wcnt;
   logic              commit;
   logic              discard;
   ee_load_t          load;

   assign pins_raw = '{
      scl:      scl_i,
      sda:      sda_i,
      strap_hi: device_select_strap_hi_i,
      strap_lo: device_select_strap_lo_i,
      wp:       write_protect_i
   };

   ee_sync #(
      .W($bits(ee_pins_t))
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (pins_raw),
      .q_o     (pins)
   );

   // Idle levels are high so the first sample after reset makes no false edge.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= pins.scl;
         sda_d <= pins.sda;
      end
   end

   assign scl_rise = pins.scl & ~scl_d;
   assign scl_fall = ~pins.scl & scl_d;

   assign start_det = pins.scl & scl_d & ~pins.sda & sda_d;

   assign stop_det = pins.scl & scl_d & pins.sda & ~sda_d;

   assign rx_state = (state == EE_ST_DEV) || (state == EE_ST_AHI) ||
                     (state == EE_ST_ALO) || (state == EE_ST_WDAT);

   assign byte_end = rx_state && scl_fall && (bitcnt == EE_BITS_PER_WORD);

   assign dev_match = (sr[7:3] == EE_DEV_CODE) &&
                      (sr[2] == pins.strap_hi) &&
                      (sr[1] == pins.strap_lo) &&
                      !busy;

   always_comb begin
      case (state)
         EE_ST_DEV:  next_after = sr[0] ? EE_ST_RD : EE_ST_AHI;
         EE_ST_AHI:  next_after = EE_ST_ALO;
         EE_ST_ALO:  next_after = EE_ST_WDAT;
         EE_ST_WDAT: next_after = EE_ST_WDAT;
         default:    next_after = EE_ST_IDLE;
      endcase
   end

   assign ld_hi   = byte_end && (state == EE_ST_AHI);
   assign ld_lo   = byte_end && (state == EE_ST_ALO);
   assign ld_data = byte_end && (state == EE_ST_WDAT);
   assign rd_load = scl_fall && !start_det && !stop_det &&
                    (((state == EE_ST_ACK) && (after == EE_ST_RD)) ||
                     (state == EE_ST_RLOAD));

   // Protocol engine. Start and stop win over any bit in flight.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state     <= EE_ST_IDLE;
         after     <= EE_ST_IDLE;
         bitcnt    <= 4'h0;
         sr        <= 8'h00;
         out_sr    <= 8'h00;
         drive_low <= 1'b0;
      end else if (start_det) begin
         state     <= EE_ST_DEV;
         bitcnt    <= 4'h0;
         drive_low <= 1'b0;
      end else if (stop_det) begin
         state     <= EE_ST_IDLE;
         bitcnt    <= 4'h0;
         drive_low <= 1'b0;
      end else begin
         case (state)
            EE_ST_DEV, EE_ST_AHI, EE_ST_ALO, EE_ST_WDAT: begin
               if (scl_rise) begin
                  sr     <= {sr[6:0], pins.sda};
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_end) begin
                  if ((state == EE_ST_DEV) && !dev_match) begin
                     state <= EE_ST_IDLE;
                  end else begin
                     drive_low <= 1'b1;
                     after     <= next_after;
                     state     <= EE_ST_ACK;
                  end
               end
            end
            EE_ST_ACK: begin
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  state  <= after;
                  if (after == EE_ST_RD) begin
                     out_sr    <= rdata;
                     drive_low <= ~rdata[7];
                  end else begin
                     drive_low <= 1'b0;
                  end
               end
            end
            EE_ST_RD: begin
               if (scl_rise) begin
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (bitcnt == EE_BITS_PER_WORD) begin
                     drive_low <= 1'b0;
                     state     <= EE_ST_RACK;
                  end else begin
                     out_sr    <= {out_sr[6:0], 1'b0};
                     drive_low <= ~out_sr[6];
                  end
               end
            end
            EE_ST_RACK: begin
               if (scl_rise) begin
                  state <= pins.sda ? EE_ST_IDLE : EE_ST_RLOAD;
               end
            end
            EE_ST_RLOAD: begin
               if (scl_fall) begin
                  out_sr    <= rdata;
                  drive_low <= ~rdata[7];
                  bitcnt    <= 4'h0;
                  state     <= EE_ST_RD;
               end
            end
            default: begin
               state     <= EE_ST_IDLE;
               drive_low <= 1'b0;
            end
         endcase
      end
   end

   // Address counter survives between transfers; only reset clears it.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         addr_cnt <= EE_ADDR_RESET;
      end else if (ld_hi) begin
         addr_cnt[15:8] <= sr;
      end else if (ld_lo) begin
         addr_cnt[7:0] <= sr;
      end else if (ld_data) begin
         addr_cnt[EE_PAGE_BITS-1:0] <= addr_cnt[EE_PAGE_BITS-1:0] + 7'h01;
      end else if (rd_load) begin
         addr_cnt <= addr_cnt + 16'h0001;
      end
   end

   // protected bytes never reach the buffer
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         page_dirty <= 1'b0;
      end else if (start_det || stop_det) begin
         page_dirty <= 1'b0;
      end else if (ld_data && !pins.wp) begin
         page_dirty <= 1'b1;
      end
   end

   assign commit  = stop_det && page_dirty && !pins.wp && !busy;
   assign discard = (start_det || stop_det) && !commit && !busy;

   assign load = '{
      idx:  addr_cnt[EE_PAGE_BITS-1:0],
      data: sr
   };

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         busy <= 1'b0;
         wcnt <= '0;
      end else if (commit) begin
         busy <= 1'b1;
         wcnt <= CW'(WRITE_CYCLES - 1);
      end else if (busy) begin
         if (wcnt == '0) begin
            busy <= 1'b0;
         end else begin
            wcnt <= wcnt - 1'b1;
         end
      end
   end

   ee_mem #(
      .PAGE_BYTES (EE_PAGE_BYTES),
      .PAGES      (EE_PAGE_COUNT)
   ) u_mem (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .load_en_i (ld_data && !pins.wp),
      .load_i    (load),
      .discard_i (discard),
      .commit_i  (commit),
      .page_i    (addr_cnt[EE_ADDR_BITS-1:EE_PAGE_BITS]),
      .raddr_i   (addr_cnt),
      .rdata_o   (rdata)
   );

   assign sda_o        = 1'b0;
   assign sda_oe_o     = drive_low;

   assign standby_o    = (state == EE_ST_IDLE) && !busy;
   assign write_busy_o = busy;

endmodule

// ==== sim/ee_target_asserts.sv ====
// Checker for the two-wire memory target, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
module ee_target_asserts #(
   parameter int unsigned WRITE_CYCLES = 200
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Watched pins.
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_i,
   input wire logic sda_oe_o,
   input wire logic write_protect_i,
   input wire logic standby_o,
   input wire logic write_busy_o
);
   int unsigned busy_cnt;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !write_busy_o)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end

   pull_low_only_a: assert property (sda_o == 1'b0)
      else $error("data pin driven high");
   busy_len_a: assert property ($fell(write_busy_o) |->
      busy_cnt == WRITE_CYCLES) else $error("write cycle length");
   busy_quiet_a: assert property (write_busy_o |-> !sda_oe_o)
      else $error("answer during write cycle");
   busy_standby_a: assert property (write_busy_o |-> !standby_o)
      else $error("standby during write cycle");
   standby_oe_a: assert property (standby_o |-> !sda_oe_o)
      else $error("pull while in standby");
   protect_a: assert property ($rose(write_busy_o) |-> !$past(write_protect_i, 3))
      else $error("write cycle while protected");
   pull_clk_low_a: assert property ($rose(sda_oe_o) |-> !$past(scl_i))
      else $error("pull began with clock high");
   pull_hold_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*3])
      else $error("pull too short");
   stop_idle_a: assert property (scl_i && $rose(sda_i) |->
      ##[1:6] (standby_o || write_busy_o)) else $error("no standby after stop");

   cover property ($fell(write_busy_o));
   cover property ($rose(sda_oe_o));
   cover property (write_protect_i && standby_o);
endmodule

// ==== sim/ee_host.sv ====
// Bus host model driving the serial clock and pulling the data wire low.
// Assumes the bench resolves the wire with a pull-up; moves on clk_i falls.
`timescale 1ns/100ps
module ee_host (
   // Clock.
   input  wire logic clk_i,
   // Bus.
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // Extra low-phase cycles; lets a scenario act as a slow host.
   int slow = 0;

   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // start from a released data line
   task automatic start();
      w(6);
      sda_low_o = 1'b0;
      w(3);
      scl_o = 1'b1;
      w(3);
      sda_low_o = 1'b1;
      w(4);
      scl_o = 1'b0;
   endtask

   task automatic stop();
      w(6);
      sda_low_o = 1'b1;
      w(2);
      scl_o = 1'b1;
      w(3);
      sda_low_o = 1'b0;
      w(4);
   endtask

   // data moves only with clock low
   task automatic clk_bit(input logic low, output logic v);
      w(3 + slow);
      sda_low_o = low;
      w(2);
      scl_o = 1'b1;
      w(1);
      v = sda_i;
      w(2);
      scl_o = 1'b0;
   endtask

   // pulse the clock until data reads high, then start while it is high
   task automatic recover(output int n);
      logic v;
      n = 0;
      v = 1'b0;
      while (!v && n < 9) begin
         w(3);
         sda_low_o = 1'b0;
         w(2);
         scl_o = 1'b1;
         w(1);
         v = sda_i;
         n++;
         if (!v) begin
            w(2);
            scl_o = 1'b0;
         end
      end
      w(2);
      sda_low_o = 1'b1;
      w(4);
      scl_o = 1'b0;
   endtask

   // msb first, then the ack slot
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--)
         clk_bit(~b[i], v);
      clk_bit(1'b0, v);
      ack = ~v;
   endtask

   task automatic rbyte(input logic more, output logic [7:0] b);
      logic v;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b0, v);
         b[i] = v;
      end
      clk_bit(more, v);
   endtask
endmodule

// ==== sim/ee_target_tb.sv ====
// Self-checking bench for the two-wire memory target driven by a host model.
// Assumes a short write cycle parameter so the run stays brief.
`timescale 1ns/100ps
module ee_target_tb
   import ee_pkg::*;
;
   localparam int WC = 200;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic strap_hi = 1'b1;
   logic strap_lo = 1'b0;
   logic wp = 1'b0;
   logic scl, sda_low, sda_o, sda_oe, standby, busy;
   wire logic sda;
   int err_total = 0;
   int num_checks = 0;

   // Open-drain wire with a pull-up.
   assign sda = ~(sda_low | sda_oe);

   initial forever #20 clk_i = ~clk_i;

   ee_target #(.WRITE_CYCLES(WC)) ee_target_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe), .device_select_strap_hi_i(strap_hi),
      .device_select_strap_lo_i(strap_lo), .write_protect_i(wp),
      .standby_o(standby), .write_busy_o(busy));
   ee_host ee_host_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input logic v, input int lim);
      int n = 0;
      while (busy !== v && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      chk({7'h0, busy}, {7'h0, v});
      if (busy !== v)
         give_verdict();
   endtask

   function automatic logic [7:0] dw(input logic [1:0] s, input logic r);
      return {EE_DEV_CODE, s, r};
   endfunction

   task automatic send(input logic [7:0] b, input logic exp);
      logic a;
      ee_host_i.wbyte(b, a);
      chk({7'h0, a}, {7'h0, exp});
   endtask

   task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d);
      ee_host_i.start();
      send(dw(2'h2, 1'b0), 1'b1);
      send(a[15:8], 1'b1);
      send(a[7:0], 1'b1);
      for (int i = 0; i < n; i++)
         send(d + 8'(i), 1'b1);
      ee_host_i.stop();
   endtask

   task automatic cur(input logic [15:0] e, input int n);
      logic [7:0] b;
      ee_host_i.start();
      send(dw(2'h2, 1'b1), 1'b1);
      for (int i = 0; i < n; i++) begin
         ee_host_i.rbyte(i < n - 1, b);
         chk(b, (i > 0) ? e[7:0] : e[15:8]);
      end
      ee_host_i.stop();
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e, input int n);
      ee_host_i.start();
      send(dw(2'h2, 1'b0), 1'b1);
      send(a[15:8], 1'b1);
      send(a[7:0], 1'b1);
      cur(e, n);
   endtask

   task automatic t_page();
      wr(16'h027e, 130, 8'h00);
      wt(1'b1, 8);
      ee_host_i.start();
      send(dw(2'h2, 1'b0), 1'b0);
      ee_host_i.stop();
      wt(1'b0, WC + 50);
      rd(16'h027d, 16'h7f80, 2);
      rd(16'h0200, 16'h0203, 2);
   endtask

   task automatic t_addr();
      logic [7:0] b;
      int n;
      ee_host_i.start();
      send(dw(2'h1, 1'b0), 1'b0);
      repeat (4) @(negedge clk_i);
      chk({7'h0, standby}, 8'h01);
      ee_host_i.start();
      send({5'h15, 2'h2, 1'b0}, 1'b0);
      strap_hi = 1'b0;
      strap_lo = 1'b1;
      ee_host_i.start();
      send(dw(2'h1, 1'b1), 1'b1);
      ee_host_i.rbyte(1'b0, b);
      chk(b, 8'h04);
      ee_host_i.stop();
      ee_host_i.start();
      send(dw(2'h1, 1'b1), 1'b1);
      ee_host_i.recover(n);
      chk(8'(n), 8'h06);
      send(dw(2'h1, 1'b1), 1'b1);
      ee_host_i.rbyte(1'b0, b);
      chk(b, 8'h06);
      ee_host_i.stop();
      strap_hi = 1'b1;
      strap_lo = 1'b0;
   endtask

   task automatic t_wp();
      wp = 1'b1;
      wr(16'h027e, 1, 8'h5a);
      repeat (8) @(negedge clk_i);
      chk({7'h0, busy}, 8'h00);
      wp = 1'b0;
      rd(16'h027e, 16'h8000, 1);
   endtask

   task automatic t_wrap();
      ee_host_i.slow = 3;
      wr(16'hffff, 1, 8'h3c);
      wt(1'b1, 8);
      wt(1'b0, WC + 50);
      wr(16'h0000, 1, 8'hc3);
      wt(1'b1, 8);
      wt(1'b0, WC + 50);
      rd(16'hffff, 16'h3cc3, 2);
      rd(16'hffff, 16'h3c00, 1);
      cur(16'hc300, 1);
   endtask

   initial begin
      repeat (12) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      chk({5'h0, standby, busy, sda_oe}, 8'h04);
      t_page();
      t_addr();
      t_wp();
      t_wrap();
      give_verdict();
   end
endmodule

bind ee_target ee_target_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) ee_target_asserts_i (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_i(sda_i),
   .sda_oe_o(sda_oe_o), .write_protect_i(write_protect_i), .standby_o(standby_o),
   .write_busy_o(write_busy_o));
